//--- usb_sie_nak_ctrl_ep0_status.sv
`timescale 1ns/10ps
module usb_sie_nak_ctrl_ep0_status
  import sie_pkg::*;
#(
  parameter int N = NUM_EP
) (
  input  wire logic                     mclk,
  input  wire logic                     arst_n,
  input  wire logic                     sfr_wr,
  input  wire logic                     sfr_rd,
  input  wire logic [7:0]               sfr_addr,
  input  wire logic [7:0]               sfr_wdata,
  output logic      [7:0]               sfr_rdata,
  output logic                          sfr_hit,
  input  wire logic                     tok_valid,
  input  wire sie_pkg::token_t          tok_kind,
  input  wire logic [EP_SEL_W-1:0]      tok_ep,
  input  wire logic                     rx_data_valid,
  input  wire logic                     rx_toggle,
  input  wire logic                     usb_bus_reset,
  input  wire logic                     bus_activity,
  input  wire logic                     suspended,
  input  wire logic [N-1:0]             size_write,
  input  wire logic [N-1:0]             in_sent,
  input  wire logic [N-1:0]             pair_odd,
  output sie_pkg::handshake_t           hs_kind,
  output logic                          hs_valid,
  output logic [EP_SEL_W-1:0]           hs_ep,
  output logic                          function_enable,
  output logic                          fifo_visible,
  output logic                          drive_k,
  output logic                          resume_detected_event,
  output logic                          sie_reinit,
  output logic [N-1:0]                  fifo_ready
);
  import sie_pkg::*;

  logic       rst_s1_r;
  logic       rst_n_r;
  logic [7:0] nak_r;
  logic [7:0] nak_nxt;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic [7:0] sta_r;
  logic [7:0] sta_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       en_d_r;
  logic       en_d_nxt;
  logic       hs_valid_r;
  logic       hs_valid_nxt;
  logic       hs_nak_r;
  logic       hs_nak_nxt;
  logic [EP_SEL_W-1:0] hs_ep_r;
  logic [EP_SEL_W-1:0] hs_ep_nxt;
  logic       tok_live;
  logic [N-1:0] nak_set;

  sie_token_if tif ();

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  assign tok_live = tok_valid && ctl_r[CTL_ENABLE_BIT];

  assign tif.tok_valid     = tok_live;
  assign tif.tok_kind      = tok_kind;
  assign tif.tok_ep        = tok_ep;
  assign tif.rx_data_valid = rx_data_valid && ctl_r[CTL_ENABLE_BIT];
  assign tif.rx_toggle     = rx_toggle;
  assign tif.fifo_ready    = fifo_ready;

  in_ready_tracker #(
    .N (N)
  ) u_ready (
    .mclk       (mclk),
    .rst_n      (rst_n_r),
    .enable     (ctl_r[CTL_ENABLE_BIT]),
    .size_write (size_write),
    .sent       (in_sent),
    .ready      (fifo_ready)
  );

  in_nak_gate u_gate (
    .tok (tif.gate)
  );

  // NAK events per endpoint; paired even FIFO stays quiet
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_nak
      if (g % 2 == 0 && g + 1 < N) begin : g_even
        assign nak_set[g] = tif.nak_valid && tif.nak_ep == EP_SEL_W'(g) && !pair_odd[g+1];
      end else begin : g_other
        assign nak_set[g] = tif.nak_valid && tif.nak_ep == EP_SEL_W'(g);
      end
    end
  endgenerate

  always_comb begin
    nak_nxt = nak_r;
    ctl_nxt = ctl_r;
    sta_nxt = sta_r;
    en_d_nxt = ctl_r[CTL_ENABLE_BIT];
    if (sfr_wr && sfr_addr == SFR_NAK_FLAGS_ADDR) begin
      nak_nxt = nak_r & sfr_wdata;
    end
    nak_nxt[N-1:0] = nak_nxt[N-1:0] | nak_set;
    nak_nxt[7:N]   = '0;
    if (sfr_wr && sfr_addr == SFR_CONTROL_ADDR) begin
      // Bus reset has no path into this register
      ctl_nxt = {5'h00, sfr_wdata[2:0]};
    end
    if (sfr_wr && sfr_addr == SFR_EP0_STATUS_ADDR && !sfr_wdata[STA_SETUP_BIT]) begin
      sta_nxt[STA_SETUP_BIT] = 1'b0;
    end
    if (tok_live && tok_ep == '0) begin
      unique case (tok_kind)
        TOK_SETUP: begin
          sta_nxt[STA_SETUP_BIT] = 1'b1;
          sta_nxt[STA_IN_BIT]    = 1'b0;
          sta_nxt[STA_OUT_BIT]   = 1'b0;
        end
        TOK_IN: begin
          sta_nxt[STA_IN_BIT]  = 1'b1;
          sta_nxt[STA_OUT_BIT] = 1'b0;
        end
        TOK_OUT: begin
          sta_nxt[STA_OUT_BIT] = 1'b1;
          sta_nxt[STA_IN_BIT]  = 1'b0;
        end
        TOK_NONE: begin
        end
      endcase
    end
    if (tif.rx_data_valid && tok_ep == '0) begin
      sta_nxt[STA_TOGGLE_BIT] = tif.rx_toggle;
    end
    // Engine restarts on the rising enable
    if (ctl_r[CTL_ENABLE_BIT] && !en_d_r) begin
      sta_nxt = EP0_STATUS_RESET;
    end
    sta_nxt[7:4] = 4'h0;
  end

  always_comb begin
    hs_valid_nxt = tok_live && tok_kind == TOK_IN;
    hs_nak_nxt   = tif.nak_valid;
    hs_ep_nxt    = tok_ep;
    rdata_nxt    = rdata_r;
    if (sfr_rd) begin
      unique case (sfr_addr)
        SFR_NAK_FLAGS_ADDR:  rdata_nxt = nak_r;
        SFR_CONTROL_ADDR:    rdata_nxt = ctl_r;
        SFR_EP0_STATUS_ADDR: rdata_nxt = sta_r;
        default:             rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      nak_r      <= NAK_FLAGS_RESET;
      ctl_r      <= CONTROL_RESET;
      sta_r      <= EP0_STATUS_RESET;
      en_d_r     <= 1'b0;
      rdata_r    <= 8'h00;
      hs_valid_r <= 1'b0;
      hs_nak_r   <= 1'b0;
      hs_ep_r    <= '0;
    end else begin
      nak_r      <= nak_nxt;
      ctl_r      <= ctl_nxt;
      sta_r      <= sta_nxt;
      en_d_r     <= en_d_nxt;
      rdata_r    <= rdata_nxt;
      hs_valid_r <= hs_valid_nxt;
      hs_nak_r   <= hs_nak_nxt;
      hs_ep_r    <= hs_ep_nxt;
    end
  end

  assign sfr_rdata       = rdata_r;
  assign sfr_hit         = sfr_addr == SFR_NAK_FLAGS_ADDR || sfr_addr == SFR_CONTROL_ADDR
                           || sfr_addr == SFR_EP0_STATUS_ADDR;
  assign hs_valid        = hs_valid_r;
  assign hs_kind         = !hs_valid_r ? HS_NONE : (hs_nak_r ? HS_NAK : HS_ACK);
  assign hs_ep           = hs_ep_r;
  assign function_enable = ctl_r[CTL_ENABLE_BIT];
  assign fifo_visible    = ctl_r[CTL_VISIBLE_BIT];
  assign drive_k         = ctl_r[CTL_WAKEUP_BIT];
  // Own K drive masked from resume detection
  assign resume_detected_event = suspended && bus_activity && !ctl_r[CTL_WAKEUP_BIT];
  assign sie_reinit      = ctl_r[CTL_ENABLE_BIT] && !en_d_r;
endmodule

//--- sie_pkg.sv
package sie_pkg;
  localparam logic [7:0] SFR_NAK_FLAGS_ADDR = 8'heb;
  localparam logic [7:0] SFR_CONTROL_ADDR   = 8'hec;
  localparam logic [7:0] SFR_EP0_STATUS_ADDR = 8'hed;
  localparam logic [7:0] NAK_FLAGS_RESET    = 8'h00;
  localparam logic [7:0] CONTROL_RESET      = 8'h00;
  localparam logic [7:0] EP0_STATUS_RESET   = 8'h00;
  localparam int         CTL_ENABLE_BIT     = 2;
  localparam int         CTL_VISIBLE_BIT    = 1;
  localparam int         CTL_WAKEUP_BIT     = 0;
  localparam int         STA_TOGGLE_BIT     = 3;
  localparam int         STA_SETUP_BIT      = 2;
  localparam int         STA_IN_BIT         = 1;
  localparam int         STA_OUT_BIT        = 0;
  localparam int         NUM_EP             = 5;
  localparam int         EP_SEL_W           = 3;
  localparam int         WAKEUP_MIN_MS      = 10;
  localparam int         WAKEUP_MAX_MS      = 15;

  typedef enum logic [1:0] {
    TOK_NONE  = 2'b00,
    TOK_OUT   = 2'b01,
    TOK_IN    = 2'b11,
    TOK_SETUP = 2'b10
  } token_t;

  typedef enum logic [1:0] {
    HS_NONE = 2'b00,
    HS_ACK  = 2'b01,
    HS_NAK  = 2'b11
  } handshake_t;
endpackage

//--- sie_token_if.sv
`timescale 1ns/10ps
interface sie_token_if;
  import sie_pkg::*;
  logic                 tok_valid;
  token_t               tok_kind;
  logic [EP_SEL_W-1:0]  tok_ep;
  logic                 rx_data_valid;
  logic                 rx_toggle;
  logic [NUM_EP-1:0]    fifo_ready;
  logic                 nak_valid;
  logic [EP_SEL_W-1:0]  nak_ep;
  modport gate (input tok_valid, tok_kind, tok_ep, fifo_ready, output nak_valid, nak_ep);
  modport top  (output tok_valid, tok_kind, tok_ep, fifo_ready, input nak_valid, nak_ep, rx_data_valid, rx_toggle);
endinterface

//--- in_ready_tracker.sv
`timescale 1ns/10ps
module in_ready_tracker
  import sie_pkg::*;
#(
  parameter int N = NUM_EP
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          enable,
  input  wire logic [N-1:0]  size_write,
  input  wire logic [N-1:0]  sent,
  output logic      [N-1:0]  ready
);
  logic [N-1:0] ready_r;
  logic [N-1:0] ready_nxt;

  // Ready set by size write, dropped once the packet went out
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!enable) begin
        ready_nxt[i] = 1'b0;
      end else if (size_write[i]) begin
        ready_nxt[i] = 1'b1;
      end else if (sent[i]) begin
        ready_nxt[i] = 1'b0;
      end else begin
        ready_nxt[i] = ready_r[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ready_r <= '0;
    end else begin
      ready_r <= ready_nxt;
    end
  end

  assign ready = ready_r;
endmodule

//--- in_nak_gate.sv
`timescale 1ns/10ps
module in_nak_gate
  import sie_pkg::*;
(
  sie_token_if.gate tok
);
  // IN to an unready FIFO is answered with NAK
  always_comb begin
    tok.nak_valid = tok.tok_valid && tok.tok_kind == TOK_IN
                    && tok.tok_ep < EP_SEL_W'(NUM_EP) && !tok.fifo_ready[tok.tok_ep];
    tok.nak_ep    = tok.tok_ep;
  end
endmodule

//--- sie_properties.sv
`timescale 1ns/10ps
module sie_properties
  import sie_pkg::*;
#(parameter int N = NUM_EP) (
  input wire logic                mclk,
  input wire logic                arst_n,
  input wire logic                sfr_wr,
  input wire logic [7:0]          sfr_addr,
  input wire logic [7:0]          sfr_wdata,
  input wire logic                tok_valid,
  input wire sie_pkg::token_t     tok_kind,
  input wire logic [EP_SEL_W-1:0] tok_ep,
  input wire logic                usb_bus_reset,
  input wire logic [N-1:0]        size_write,
  input wire sie_pkg::handshake_t hs_kind,
  input wire logic                hs_valid,
  input wire logic [EP_SEL_W-1:0] hs_ep,
  input wire logic                function_enable,
  input wire logic                fifo_visible,
  input wire logic                drive_k,
  input wire logic                resume_detected_event,
  input wire logic                sie_reinit,
  input wire logic [N-1:0]        fifo_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire ctl_wr = sfr_wr && sfr_addr == SFR_CONTROL_ADDR;
  a_nak_unready: assert property (tok_valid && tok_kind == TOK_IN && function_enable && !fifo_ready[tok_ep]
    |=> hs_valid && hs_kind == HS_NAK && hs_ep == $past(tok_ep)) else $error("NAK answer missing");
  a_idle_disabled: assert property (tok_valid && !function_enable |=> !hs_valid)
    else $error("answer while disabled");
  a_enable_write: assert property (ctl_wr |=> function_enable == $past(sfr_wdata[2]))
    else $error("enable bit wrong");
  a_visible_write: assert property (ctl_wr |=> fifo_visible == $past(sfr_wdata[1]))
    else $error("visible bit wrong");
  a_wakeup_drive: assert property (ctl_wr |=> drive_k == $past(sfr_wdata[0]))
    else $error("K drive wrong");
  a_bus_reset_keep: assert property (usb_bus_reset && !ctl_wr |=> $stable(function_enable))
    else $error("bus reset moved enable");
  a_no_self_resume: assert property (drive_k |-> !resume_detected_event)
    else $error("own resume flagged");
  a_reinit_pulse: assert property ($rose(function_enable) |-> sie_reinit)
    else $error("reinit missing");
  a_ready_by_size: assert property ((fifo_ready & ~$past(fifo_ready) & ~$past(size_write)) == '0)
    else $error("ready without size write");
  c_nak: cover property (hs_valid && hs_kind == HS_NAK);
  c_ack: cover property (hs_valid && hs_kind == HS_ACK);
  c_wake: cover property (drive_k);
endmodule

//--- usb_host_model.sv
`timescale 1ns/10ps
module usb_host_model
  import sie_pkg::*;
(
  input  wire logic          mclk,
  output sie_pkg::token_t    tok_kind,
  output logic               tok_valid,
  output logic [EP_SEL_W-1:0] tok_ep,
  output logic               rx_data_valid,
  output logic               rx_toggle
);
  initial begin
    tok_valid = 1'b0;
    tok_kind = TOK_NONE;
    tok_ep = '0;
    rx_data_valid = 1'b0;
    rx_toggle = 1'b0;
  end
  // Token after idle gap; OUT and SETUP carry a data packet
  task automatic send(input token_t k, input logic [2:0] e, input logic t, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    tok_valid <= 1'b1;
    tok_kind <= k;
    tok_ep <= e;
    @(posedge mclk);
    tok_valid <= 1'b0;
    tok_kind <= TOK_NONE;
    tok_ep <= (k == TOK_IN) ? ~e : e;
    if (k != TOK_IN) begin
      rx_data_valid <= 1'b1;
      rx_toggle <= t;
      @(posedge mclk);
      rx_data_valid <= 1'b0;
      rx_toggle <= ~t;
      tok_ep <= ~e;
    end
  endtask
endmodule

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import sie_pkg::*;
  logic       mclk, arst_n, sfr_wr, sfr_rd, usb_bus_reset, bus_activity, suspended, sfr_hit;
  logic       tok_valid, rx_data_valid, rx_toggle, hs_valid, function_enable, fifo_visible;
  logic       drive_k, resume_detected_event, sie_reinit;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v, exp_flags, st;
  logic [4:0] size_write, pair_odd, fifo_ready, in_sent;
  logic [2:0] tok_ep, hs_ep, ep;
  token_t     tok_kind;
  handshake_t hs_kind;
  token_t     ks[3] = '{TOK_SETUP, TOK_IN, TOK_OUT};
  int         fail_count = 0, checks = 0, seed = 61007;
  usb_sie_nak_ctrl_ep0_status dut (.mclk, .arst_n, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit,
    .tok_valid, .tok_kind, .tok_ep, .rx_data_valid, .rx_toggle, .usb_bus_reset, .bus_activity, .suspended,
    .size_write, .in_sent, .pair_odd, .hs_kind, .hs_valid, .hs_ep, .function_enable, .fifo_visible,
    .drive_k, .resume_detected_event, .sie_reinit, .fifo_ready);
  usb_host_model host (.mclk, .tok_kind, .tok_valid, .tok_ep, .rx_data_valid, .rx_toggle);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [7:0] status_nxt(logic [7:0] s, token_t k, logic t);
    if (k == TOK_SETUP) return {4'h0, t, 3'b100};
    if (k == TOK_IN) return {4'h0, s[3:2], 2'b10};
    return {4'h0, t, s[2], 2'b01};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    stop_test;
  end
  initial begin
    {arst_n, sfr_wr, sfr_rd, usb_bus_reset, bus_activity, suspended} = '0;
    {sfr_addr, sfr_wdata, size_write, pair_odd, in_sent} = '0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      rd(8'heb + 8'(i), v);
      chk("reset value", 8'h00, v);
      chk("addr hit", 8'(i < 3), 8'(sfr_hit));
    end
    host.send(TOK_IN, 3'd1, 1'b0, 0);
    #1 chk("hs while off", 8'h00, 8'(hs_valid));
    wr(SFR_CONTROL_ADDR, 8'h04);
    #1 chk("enable", 8'h01, 8'(function_enable));
    chk("reinit", 8'h01, 8'(sie_reinit));
    $display("test reset and enable done");
    exp_flags = 8'h00;
    st = 8'h00;
    repeat (12) begin
      ep = 3'(unsigned'($random(seed)) % 5);
      host.send(TOK_IN, ep, 1'b0, $random(seed) & 3);
      #1 chk("hs kind", 8'(HS_NAK), 8'(hs_kind));
      chk("hs ep", 8'(ep), 8'(hs_ep));
      exp_flags |= 8'h01 << ep;
      if (ep == 3'd0) st = status_nxt(st, TOK_IN, 1'b0);
    end
    rd(SFR_NAK_FLAGS_ADDR, v);
    chk("nak flags", exp_flags, v);
    wr(SFR_NAK_FLAGS_ADDR, 8'hff);
    rd(SFR_NAK_FLAGS_ADDR, v);
    chk("flags keep", exp_flags, v);
    wr(SFR_NAK_FLAGS_ADDR, 8'hfd);
    rd(SFR_NAK_FLAGS_ADDR, v);
    chk("flags clear", exp_flags & 8'hfd, v);
    @(posedge mclk) size_write <= 5'h04;
    @(posedge mclk) size_write <= 5'h00;
    #1 chk("fifo ready", 8'h04, 8'(fifo_ready));
    host.send(TOK_IN, 3'd2, 1'b0, 0);
    #1 chk("ready ack", 8'(HS_ACK), 8'(hs_kind));
    @(posedge mclk) in_sent <= 5'h04;
    @(posedge mclk) in_sent <= 5'h00;
    host.send(TOK_IN, 3'd2, 1'b0, 0);
    #1 chk("sent nak", 8'(HS_NAK), 8'(hs_kind));
    wr(SFR_NAK_FLAGS_ADDR, 8'h00);
    pair_odd <= 5'h02;
    host.send(TOK_IN, 3'd0, 1'b0, 1);
    st = status_nxt(st, TOK_IN, 1'b0);
    rd(SFR_NAK_FLAGS_ADDR, v);
    chk("paired even flag", 8'h00, v & 8'h01);
    pair_odd <= 5'h00;
    $display("test nak flags done");
    for (int i = 0; i < 3; i++) begin
      host.send(ks[i], 3'd0, i < 2, i);
      st = status_nxt(st, ks[i], i < 2);
      rd(SFR_EP0_STATUS_ADDR, v);
      chk("ep0 status", st, v);
    end
    wr(SFR_EP0_STATUS_ADDR, 8'h00);
    rd(SFR_EP0_STATUS_ADDR, v);
    chk("setup clear", st & 8'hfb, v);
    wr(SFR_CONTROL_ADDR, 8'h00);
    wr(SFR_CONTROL_ADDR, 8'h04);
    rd(SFR_EP0_STATUS_ADDR, v);
    chk("status reinit", 8'h00, v);
    $display("test ep0 status done");
    usb_bus_reset <= 1'b1;
    suspended <= 1'b1;
    bus_activity <= 1'b1;
    wr(SFR_CONTROL_ADDR, 8'h07);
    #1 chk("k drive", 8'h01, 8'(drive_k));
    chk("visible", 8'h01, 8'(fifo_visible));
    chk("own resume", 8'h00, 8'(resume_detected_event));
    repeat (3) @(posedge mclk);
    #1 chk("enable kept", 8'h01, 8'(function_enable));
    // Wakeup hold cut short to fit the run
    wr(SFR_CONTROL_ADDR, 8'h04);
    #1 chk("k released", 8'h00, 8'(drive_k));
    chk("host resume", 8'h01, 8'(resume_detected_event));
    $display("test control done");
    stop_test;
  end
endmodule
bind usb_sie_nak_ctrl_ep0_status sie_properties #(.N(N)) chk_i (.mclk, .arst_n, .sfr_wr, .sfr_addr, .sfr_wdata,
  .tok_valid, .tok_kind, .tok_ep, .usb_bus_reset, .size_write, .hs_kind, .hs_valid, .hs_ep, .function_enable,
  .fifo_visible, .drive_k, .resume_detected_event, .sie_reinit, .fifo_ready);
